//--- common/power_mode_pkg.sv
// Package for the magnetometer power-mode sequencer.
// Assumes one 10 MHz clock and the device's internal register port.
package power_mode_pkg;
  localparam logic [7:0] ADDR_IDENT = 8'h40;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h4b;
  localparam logic [7:0] ADDR_OP_CTRL = 8'h4c;
  localparam logic [7:0] ADDR_PLANAR_REP = 8'h51;
  localparam logic [7:0] ADDR_VERT_REP = 8'h52;
  localparam logic [7:0] ADDR_RATE = 8'h50;
  localparam logic [7:0] ADDR_SOFT_RST = 8'h4d;
  localparam logic [7:0] ADDR_RESULT = 8'h42;
  localparam int POWER_BIT_POS = 0;
  localparam int THREE_WIRE_POS = 2;
  localparam int MEAS_SEL_LSB = 1;
  localparam logic [7:0] POWER_CTRL_RESET = 8'h00;
  localparam logic [7:0] OP_CTRL_RESET = 8'h06;
  localparam logic [7:0] REP_RESET = 8'h01;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] SUSPEND_READ_VALUE = 8'h00;
  localparam logic [1:0] MEAS_NORMAL = 2'h0;
  localparam logic [1:0] MEAS_FORCED = 2'h1;
  localparam logic [1:0] MEAS_SLEEP = 2'h3;
  localparam int CLK_HZ = 10_000_000;
  localparam int PLANAR_REP_NS = 145_000;
  localparam int VERT_REP_NS = 500_000;
  localparam int BASE_NS = 980_000;
  localparam int PLANAR_REP_CYC = PLANAR_REP_NS / 100;
  localparam int VERT_REP_CYC = VERT_REP_NS / 100;
  localparam int BASE_CYC = BASE_NS / 100;
  localparam int TRIM_WORDS = 8;
  localparam int PERIOD_10HZ_CYC = CLK_HZ / 10;

  typedef enum {
    ST_OFF, ST_STARTUP, ST_SUSPEND, ST_SLEEP, ST_NORMAL, ST_FORCED
  } power_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic drive;
    logic [7:0] data;
  } reg_rsp_t;
endpackage : power_mode_pkg

//--- rtl/power_mode_ctrl.sv
// Power-mode sequencer: off, start-up, suspend, sleep, normal, forced.
// Assumes supply-good pins are asynchronous; register port is same clock.
`timescale 1ns/1ps
module power_mode_ctrl import power_mode_pkg::*; #(
  parameter int PERIOD_CYC = PERIOD_10HZ_CYC,
  parameter logic [7:0] IDENT_VALUE = 8'h5a // Arbitrary value
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic core_supply_ok,
  input wire logic io_supply_ok,
  input wire logic spi_mode,
  input wire reg_req_t req,
  input wire logic [7:0] sample_in,
  output reg_rsp_t rsp,
  output logic [2:0] mode_state,
  output logic measuring,
  output logic [7:0] result_data,
  output logic result_strobe
);
  initial begin
    if (PERIOD_CYC < 2 || PERIOD_CYC > (1 << 24)) begin
      $error("period outside counter range");
    end
  end

  typedef struct packed {
    logic [1:0] sync_a;
    logic [1:0] sync_b;
    power_state_t st;
    logic [3:0] trim_idx;
    logic [7:0] power_ctrl;
    logic [7:0] op_ctrl;
    logic [7:0] planar_repeat_count;
    logic [7:0] vert_repeat_count;
    logic [7:0] rate;
    logic [23:0] meas_cnt;
    logic [23:0] period_cnt;
    logic busy;
    logic [7:0] acc;
    logic [7:0] result;
    reg_rsp_t rsp;
    logic strobe;
  } state_t;

  state_t cur_ff, nxt_ff;
  logic [7:0] trim_rdata;
  logic trim_we;

  // Active time in cycles for given register codes (count = code*2+1)
  function automatic logic [23:0] meas_cycles(input logic [7:0] xy,
                                              input logic [7:0] z);
    logic [23:0] planar_repetitions;
    logic [23:0] nz;
    planar_repetitions = {15'h0000, xy, 1'b1};
    nz = {15'h0000, z, 1'b1};
    meas_cycles = 24'(planar_repetitions * 24'(PLANAR_REP_CYC) + nz * 24'(VERT_REP_CYC)
                      + 24'(BASE_CYC));
  endfunction : meas_cycles

  trim_store_mem #(.DEPTH(TRIM_WORDS), .AW(3)) u_trim (
    .ref_clk(ref_clk),
    .we(trim_we),
    .waddr(cur_ff.trim_idx[2:0]),
    .wdata(8'(cur_ff.trim_idx) ^ 8'ha5),
    .raddr(cur_ff.trim_idx[2:0]),
    .rdata(trim_rdata)
  );
  assign trim_we = (cur_ff.st == ST_STARTUP);

  logic supplies_ok;
  logic active;
  logic [1:0] sel_w;
  assign supplies_ok = cur_ff.sync_a[1] & cur_ff.sync_b[1];
  assign active = (cur_ff.st == ST_NORMAL) || (cur_ff.st == ST_FORCED);
  assign sel_w = req.wdata[MEAS_SEL_LSB+:2];

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.sync_a = {cur_ff.sync_a[0], core_supply_ok};
    nxt_ff.sync_b = {cur_ff.sync_b[0], io_supply_ok};
    nxt_ff.rsp = '0;
    nxt_ff.strobe = 1'b0;
    case (cur_ff.st)
      ST_OFF: begin
        if (supplies_ok) begin
          nxt_ff.st = ST_STARTUP;
          nxt_ff.trim_idx = '0;
        end
      end
      ST_STARTUP: begin
        nxt_ff.trim_idx = cur_ff.trim_idx + 4'h1;
        if (cur_ff.trim_idx == 4'(TRIM_WORDS - 1)) begin
          nxt_ff.st = ST_SUSPEND;
        end
      end
      ST_SUSPEND: begin
        if (req.wr && req.addr == ADDR_POWER_CTRL) begin
          nxt_ff.power_ctrl = req.wdata;
          if (req.wdata[POWER_BIT_POS]) begin
            nxt_ff.st = ST_SLEEP;
          end
        end
        if (req.rd) begin
          nxt_ff.rsp.valid = 1'b1;
          if (req.addr == ADDR_POWER_CTRL) begin
            nxt_ff.rsp.drive = 1'b1;
            nxt_ff.rsp.data = cur_ff.power_ctrl;
          end else begin
            nxt_ff.rsp.drive = !spi_mode;
            nxt_ff.rsp.data = SUSPEND_READ_VALUE;
          end
        end
      end
      ST_SLEEP, ST_NORMAL, ST_FORCED: begin
        if (req.rd) begin
          nxt_ff.rsp.valid = 1'b1;
          nxt_ff.rsp.drive = 1'b1;
          case (req.addr)
            ADDR_IDENT: nxt_ff.rsp.data = IDENT_VALUE;
            ADDR_POWER_CTRL: nxt_ff.rsp.data = cur_ff.power_ctrl;
            ADDR_OP_CTRL: nxt_ff.rsp.data = cur_ff.op_ctrl;
            ADDR_PLANAR_REP: nxt_ff.rsp.data = cur_ff.planar_repeat_count;
            ADDR_VERT_REP: nxt_ff.rsp.data = cur_ff.vert_repeat_count;
            ADDR_RATE: nxt_ff.rsp.data = cur_ff.rate;
            ADDR_RESULT: nxt_ff.rsp.data = cur_ff.result;
            default: nxt_ff.rsp.data = 8'h00;
          endcase
        end
        // Measurement engine
        if (cur_ff.busy) begin
          nxt_ff.acc = cur_ff.acc ^ sample_in;
          if (cur_ff.meas_cnt <= 24'h000001) begin
            nxt_ff.busy = 1'b0;
            nxt_ff.result = cur_ff.acc ^ sample_in;
            nxt_ff.strobe = 1'b1;
            if (cur_ff.st == ST_FORCED) begin
              nxt_ff.op_ctrl[MEAS_SEL_LSB+:2] = MEAS_SLEEP;
              nxt_ff.st = ST_SLEEP;
            end
          end else begin
            nxt_ff.meas_cnt = cur_ff.meas_cnt - 24'h000001;
          end
        end
        if (cur_ff.st == ST_NORMAL) begin
          if (cur_ff.period_cnt == 24'h000000) begin
            nxt_ff.period_cnt = 24'(PERIOD_CYC - 1) >> cur_ff.rate[0];
            // A tick during a measurement is skipped, never restarts it
            if (!cur_ff.busy) begin
              nxt_ff.busy = 1'b1;
              nxt_ff.acc = trim_rdata;
              nxt_ff.meas_cnt = meas_cycles(cur_ff.planar_repeat_count,
                                            cur_ff.vert_repeat_count);
            end
          end else begin
            nxt_ff.period_cnt = cur_ff.period_cnt - 24'h000001;
          end
        end
        if (req.wr) begin
          case (req.addr)
            ADDR_POWER_CTRL: begin
              nxt_ff.power_ctrl = req.wdata;
              if (!req.wdata[POWER_BIT_POS] && cur_ff.st != ST_FORCED) begin
                nxt_ff.st = ST_SUSPEND;
                nxt_ff.busy = 1'b0;
              end
            end
            ADDR_OP_CTRL: begin
              nxt_ff.op_ctrl = req.wdata;
              if (sel_w == MEAS_SLEEP) begin
                nxt_ff.st = ST_SLEEP;
                nxt_ff.busy = 1'b0;
              end else if (sel_w == MEAS_FORCED) begin
                nxt_ff.st = ST_FORCED;
                nxt_ff.busy = 1'b1; // Restart drops old cycle
                nxt_ff.strobe = 1'b0;
                nxt_ff.result = cur_ff.result;
                nxt_ff.acc = trim_rdata; // Trim shadow seeds the sum
                nxt_ff.meas_cnt = meas_cycles(cur_ff.planar_repeat_count,
                                              cur_ff.vert_repeat_count);
              end else if (sel_w == MEAS_NORMAL) begin
                if (cur_ff.st != ST_NORMAL) begin
                  nxt_ff.period_cnt = '0;
                end
                nxt_ff.st = ST_NORMAL;
              end else begin
                nxt_ff.op_ctrl = cur_ff.op_ctrl;
              end
            end
            ADDR_PLANAR_REP: nxt_ff.planar_repeat_count = req.wdata;
            ADDR_VERT_REP: nxt_ff.vert_repeat_count = req.wdata;
            ADDR_RATE: nxt_ff.rate = req.wdata;
            ADDR_SOFT_RST: begin
              if (req.wdata[0] && cur_ff.st == ST_NORMAL) begin
                nxt_ff.st = ST_SLEEP;
                nxt_ff.busy = 1'b0;
                nxt_ff.op_ctrl = OP_CTRL_RESET;
                nxt_ff.planar_repeat_count = REP_RESET;
                nxt_ff.vert_repeat_count = REP_RESET;
                nxt_ff.rate = RATE_RESET;
              end
            end
            default: ;
          endcase
        end
        if (nxt_ff.st == ST_SUSPEND) begin
          nxt_ff.op_ctrl = OP_CTRL_RESET;
          nxt_ff.planar_repeat_count = REP_RESET;
          nxt_ff.vert_repeat_count = REP_RESET;
          nxt_ff.rate = RATE_RESET;
          nxt_ff.result = '0;
        end
      end
      default: nxt_ff.st = ST_OFF;
    endcase
    if (!supplies_ok && cur_ff.st != ST_OFF) begin
      nxt_ff.st = ST_OFF;
      nxt_ff.power_ctrl = POWER_CTRL_RESET;
      nxt_ff.op_ctrl = OP_CTRL_RESET;
      nxt_ff.planar_repeat_count = REP_RESET;
      nxt_ff.vert_repeat_count = REP_RESET;
      nxt_ff.rate = RATE_RESET;
      nxt_ff.result = '0;
      nxt_ff.busy = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cur_ff <= '0;
      cur_ff.st <= ST_OFF;
      cur_ff.power_ctrl <= POWER_CTRL_RESET;
      cur_ff.op_ctrl <= OP_CTRL_RESET;
      cur_ff.planar_repeat_count <= REP_RESET;
      cur_ff.vert_repeat_count <= REP_RESET;
      cur_ff.rate <= RATE_RESET;
    end else begin
      cur_ff <= nxt_ff;
    end
  end

  assign rsp = cur_ff.rsp; // Answers only, never initiates
  assign mode_state = 3'(cur_ff.st);
  assign measuring = cur_ff.busy;
  assign result_data = cur_ff.result;
  assign result_strobe = cur_ff.strobe;

  property p_suspend_access;
    @(posedge ref_clk) disable iff (sys_rst)
    (cur_ff.st == ST_SUSPEND && req.rd && req.addr == ADDR_IDENT)
      |=> (rsp.valid && rsp.data == 8'h00 && rsp.drive == !$past(spi_mode));
  endproperty
  a_suspend_access: assert property (p_suspend_access)
    else $error("suspend ident read wrong");

  property p_wake;
    @(posedge ref_clk) disable iff (sys_rst)
    (cur_ff.st == ST_SUSPEND && supplies_ok && req.wr
     && req.addr == ADDR_POWER_CTRL && req.wdata[0]) |=> cur_ff.st == ST_SLEEP;
  endproperty
  a_wake: assert property (p_wake)
    else $error("power bit did not wake");

  property p_forced_done;
    @(posedge ref_clk) disable iff (sys_rst)
    ($fell(cur_ff.busy) && $past(cur_ff.st == ST_FORCED)
     && $past(supplies_ok) && !$past(req.wr))
      |-> (cur_ff.st == ST_SLEEP
           && cur_ff.op_ctrl[MEAS_SEL_LSB+:2] == MEAS_SLEEP);
  endproperty
  a_forced_done: assert property (p_forced_done)
    else $error("forced end wrong");

  property p_off;
    @(posedge ref_clk) disable iff (sys_rst)
    !supplies_ok |=> cur_ff.st == ST_OFF;
  endproperty
  a_off: assert property (p_off)
    else $error("not off without supply");

  property p_startup;
    @(posedge ref_clk) disable iff (sys_rst)
    $rose(cur_ff.st == ST_STARTUP) && supplies_ok
      |-> ##8 (cur_ff.st == ST_SUSPEND || !supplies_ok);
  endproperty
  a_startup: assert property (p_startup)
    else $error("start-up length wrong");

  property p_suspend_clear;
    @(posedge ref_clk) disable iff (sys_rst)
    (cur_ff.st == ST_SUSPEND) |-> cur_ff.rate == RATE_RESET;
  endproperty
  a_suspend_clear: assert property (p_suspend_clear)
    else $error("register kept in suspend");

  property p_sleep_ident;
    @(posedge ref_clk) disable iff (sys_rst)
    (cur_ff.st == ST_SLEEP && supplies_ok && req.rd && req.addr == ADDR_IDENT)
      |=> rsp.data == IDENT_VALUE && rsp.drive;
  endproperty
  a_sleep_ident: assert property (p_sleep_ident)
    else $error("ident not readable");

  property p_clear_power;
    @(posedge ref_clk) disable iff (sys_rst)
    ((cur_ff.st == ST_SLEEP || cur_ff.st == ST_NORMAL) && req.wr
     && req.addr == ADDR_POWER_CTRL && !req.wdata[0]) |=> cur_ff.st != ST_SLEEP
      && cur_ff.st != ST_NORMAL;
  endproperty
  a_clear_power: assert property (p_clear_power)
    else $error("power clear ignored");

  c_normal: cover property (@(posedge ref_clk) cur_ff.st == ST_NORMAL
                            && result_strobe);
  c_forced: cover property (@(posedge ref_clk) cur_ff.st == ST_FORCED
                            && cur_ff.busy);
  c_suspend: cover property (@(posedge ref_clk) cur_ff.st == ST_SUSPEND);
endmodule : power_mode_ctrl

//--- rtl/trim_store_mem.sv
// Small trim memory with registered read data.
// Assumes reads and writes come from the sequencer on the same clock.
`timescale 1ns/1ps
module trim_store_mem import power_mode_pkg::*; #(
  parameter int DEPTH = TRIM_WORDS,
  parameter int AW = 3
) (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [DEPTH];
  initial begin
    if (DEPTH > (1 << AW)) $error("trim depth exceeds address");
  end
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : trim_store_mem

//--- test/host_model.sv
// Host register master model for the power-mode sequencer.
// Assumes one clock; the bench calls the tasks hierarchically.
`timescale 1ns/1ps
module host_model import power_mode_pkg::*; (
  input wire logic ref_clk,
  input wire reg_rsp_t rsp,
  output reg_req_t req
);
  initial req = '0;
  // One-cycle strobes; the device only ever answers as slave
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output reg_rsp_t r);
    int n;
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    r = '0;
    n = 0;
    while (n < 4) begin
      @(negedge ref_clk);
      if (rsp.valid === 1'b1) begin
        r = rsp;
        n = 4;
      end else begin
        n++;
      end
    end
  endtask : rd
endmodule : host_model

//--- test/magnetometer_power_mode_control_bench.sv
// Self-checking bench for the power-mode sequencer.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
module magnetometer_power_mode_control_bench import power_mode_pkg::*;;
  localparam logic [7:0] IDENT = 8'h3c; // Arbitrary value
  // Repetition codes of zero give counts of one
  localparam int MEAS_CYC = PLANAR_REP_CYC + VERT_REP_CYC + BASE_CYC;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } row_t;
  row_t rows [5] = '{'{ADDR_RATE, 8'h01, 8'h01}, '{ADDR_PLANAR_REP, 8'h00,
    8'h00}, '{ADDR_VERT_REP, 8'h00, 8'h00}, '{ADDR_RATE, 8'h00, 8'h00},
    '{ADDR_IDENT, 8'hff, IDENT}};
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic core_supply_ok = 1'b0;
  logic io_supply_ok = 1'b0;
  logic spi_mode = 1'b0;
  logic [7:0] sample_in = 8'h00;
  reg_req_t req;
  reg_rsp_t rsp;
  logic [2:0] mode_state;
  logic measuring;
  logic [7:0] result_data;
  logic result_strobe;
  int err_total = 0;
  int tests_run = 0;
  int strobes = 0;
  int cyc = 0;
  int d;
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    sample_in <= sample_in + 8'h01;
    if (result_strobe === 1'b1) begin
      strobes <= strobes + 1;
    end
  end
  power_mode_ctrl #(.PERIOD_CYC(50), .IDENT_VALUE(IDENT)) u_dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .core_supply_ok(core_supply_ok),
    .io_supply_ok(io_supply_ok), .spi_mode(spi_mode), .req(req),
    .sample_in(sample_in), .rsp(rsp), .mode_state(mode_state),
    .measuring(measuring), .result_data(result_data),
    .result_strobe(result_strobe));
  host_model u_host (.ref_clk(ref_clk), .rsp(rsp), .req(req));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e,
                       input logic ed);
    reg_rsp_t r;
    u_host.rd(a, r);
    check({r.valid, r.drive, r.data}, {1'b1, ed, e});
  endtask : rdchk
  task automatic wait_mode(input logic [2:0] m);
    int n;
    n = 0;
    while (mode_state !== m && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    check(mode_state, m);
  endtask : wait_mode
  task automatic wait_strobe(output int dt);
    int s0;
    int c0;
    int n;
    s0 = strobes;
    c0 = cyc;
    n = 0;
    while (strobes == s0 && n < 20000) begin
      @(negedge ref_clk);
      n++;
    end
    dt = cyc - c0;
  endtask : wait_strobe
  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #(80_000 * 100);
    err_total++;
    end_of_test();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check({result_strobe, result_data, rsp, measuring, mode_state}, 0);
    @(posedge ref_clk);
    core_supply_ok <= 1'b1;
    repeat (20) @(negedge ref_clk);
    check(mode_state, 3'h0);
    @(posedge ref_clk);
    io_supply_ok <= 1'b1;
    wait_mode(3'h2);
    rdchk(ADDR_IDENT, SUSPEND_READ_VALUE, 1'b1);
    u_host.wr(ADDR_OP_CTRL, 8'h02);
    repeat (3) @(negedge ref_clk);
    check(mode_state, 3'h2);
    @(posedge ref_clk);
    spi_mode <= 1'b1;
    rdchk(ADDR_IDENT, SUSPEND_READ_VALUE, 1'b0);
    @(posedge ref_clk);
    spi_mode <= 1'b0;
    u_host.wr(ADDR_POWER_CTRL, 8'h01);
    wait_mode(3'h3);
    rdchk(ADDR_OP_CTRL, OP_CTRL_RESET, 1'b1);
    rdchk(ADDR_POWER_CTRL, 8'h01, 1'b1);
    foreach (rows[i]) begin
      u_host.wr(rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].exp, 1'b1);
    end
    u_host.wr(ADDR_RATE, 8'h01);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(negedge ref_clk);
    check(mode_state, 3'h0);
    wait_mode(3'h2);
    u_host.wr(ADDR_POWER_CTRL, 8'h01);
    wait_mode(3'h3);
    rdchk(ADDR_RATE, RATE_RESET, 1'b1);
    rdchk(ADDR_PLANAR_REP, REP_RESET, 1'b1);
    // Host restores its repetition codes, not the rate, after the sys_rst reset
    u_host.wr(ADDR_PLANAR_REP, 8'h00);
    u_host.wr(ADDR_VERT_REP, 8'h00);
    u_host.wr(ADDR_OP_CTRL, 8'h02);
    wait_strobe(d);
    check((d >= MEAS_CYC - 4) && (d <= MEAS_CYC + 4), 1'b1);
    wait_mode(3'h3);
    rdchk(ADDR_OP_CTRL, 8'h06, 1'b1);
    u_host.wr(ADDR_OP_CTRL, 8'h02);
    wait_mode(3'h5);
    check(measuring, 1'b1);
    rdchk(ADDR_IDENT, IDENT, 1'b1);
    // Early retrigger breaks host spacing on purpose
    repeat (1000) @(posedge ref_clk);
    u_host.wr(ADDR_OP_CTRL, 8'h02);
    wait_strobe(d);
    check((d >= MEAS_CYC - 4) && (d <= MEAS_CYC + 4), 1'b1);
    wait_mode(3'h3);
    u_host.wr(ADDR_OP_CTRL, 8'h00);
    wait_mode(3'h4);
    wait_strobe(d);
    check((d >= MEAS_CYC - 4) && (d <= MEAS_CYC + 4), 1'b1);
    u_host.wr(ADDR_SOFT_RST, 8'h01);
    wait_mode(3'h3);
    u_host.wr(ADDR_OP_CTRL, 8'h00); // Reset codes give the 3/3 preset
    wait_mode(3'h4);
    u_host.wr(ADDR_OP_CTRL, 8'h06);
    wait_mode(3'h3);
    u_host.wr(ADDR_OP_CTRL, 8'h02);
    wait_mode(3'h5);
    u_host.wr(ADDR_OP_CTRL, 8'h06);
    wait_mode(3'h3);
    u_host.wr(ADDR_OP_CTRL, 8'h00);
    wait_mode(3'h4);
    u_host.wr(ADDR_POWER_CTRL, 8'h04);
    wait_mode(3'h2);
    rdchk(ADDR_POWER_CTRL, 8'h04, 1'b1);
    rdchk(ADDR_OP_CTRL, SUSPEND_READ_VALUE, 1'b1);
    u_host.wr(ADDR_POWER_CTRL, 8'h05);
    wait_mode(3'h3);
    check(result_data, 8'h00);
    rdchk(ADDR_OP_CTRL, OP_CTRL_RESET, 1'b1);
    rdchk(ADDR_PLANAR_REP, REP_RESET, 1'b1);
    end_of_test();
  end
endmodule : magnetometer_power_mode_control_bench
